// ### core/rsp_reset_sleep.sv
// Reset sequencer and sleep-time power gating for a small microcontroller.
// ============================================================================
// Overview of operation
// - Enabled ADC stays active in all sleeps.
// - ADC re-enable makes next conversion extended.
// - Deep sleeps disable the analog comparator.
// - Comparator on bandgap keeps reference on.
// - Brown-out fuse keeps detector on always.
// - Reference on only when detector/comparator/ADC need.
// - Enabled watchdog keeps running in sleep.
// - Deep sleeps disable inputs except wake pins.
// - Reset loads registers, start at vector.
// - Any source resets ports asynchronously; here the port reset is registered from the synchronised sources.
// - Delay counter stretches reset after sources.
// - Exactly four reset sources are combined.
// - Long enough pin low resets clocklessly; here the pin is sampled through a clocked synchroniser.
// - Watchdog reset only while watchdog enabled.
// - Power-on starts delay, drop reasserts immediately.
// - Pin rise starts delay, then release.
// - Brown-out asserts immediately, releases via delay.
// - Level fuse picks 2.7V or 4.0V.
// - Brown-out needs dip longer than 2us.
// - Watchdog gives one-cycle pulse, delay after.
// - Four cause flags, cleared by writing zero.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps

module rsp_reset_sleep
  import rsp_pkg::*;
#(
  parameter int TIMEOUT_W      = 20,
  parameter int WAKE_PINS      = 8,
  parameter logic [TIMEOUT_W-1:0] TIMEOUT_DEFAULT = 20'd16384
)
(
  // Clock, reset and enable
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 clkEn,
  // Analog, pin and watchdog reset sources
  input  wire logic                 supplyAbovePor,
  input  wire logic                 supplyBelowBrownout,
  input  wire logic                 resetPin_b,
  input  wire logic                 watchdogExpire,
  // Fuses
  input  wire logic                 brownout_enable_fuse,
  input  wire logic                 brownout_level_fuse,
  input  wire logic [TIMEOUT_SEL_W-1:0] clock_select_fuses,
  // Wake-up pin mask
  input  wire logic [WAKE_PINS-1:0] wakePinMask,
  // Reset outputs
  output logic                      portReset_b,
  output logic                      coreReset_b,
  output logic                      watchdogResetPulse,
  // Power gating outputs
  output logic                      adcPowerOn,
  output logic                      adcExtendedNext,
  output logic                      comparatorOn,
  output logic                      referenceOn,
  output logic                      brownoutDetectorOn,
  output logic                      watchdogRun,
  output logic [WAKE_PINS-1:0]      inputBufferEn,
  output logic [12:0]               brownout_trigger_level,
  // AXI4-Lite slave
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready
);
  import rsp_pkg::*;

  // ==========================================================================
  // Timeout selection
  // ==========================================================================
  // Map the two low clock-select fuse bits to a delay length; each step halves the count.
  function automatic logic [TIMEOUT_W-1:0] timeoutFor(input logic [TIMEOUT_SEL_W-1:0] sel);
    logic [TIMEOUT_W-1:0] t;
    t = TIMEOUT_DEFAULT >> sel[1:0];
    if (t == '0)
    begin
      t = TIMEOUT_W'(1);
    end
    return t;
  endfunction

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [1:0] porSync;
  logic [1:0] bodSync;
  logic [1:0] pinSync;
  logic [1:0] wdtSync;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      porSync <= 2'h0;
      bodSync <= 2'h0;
      // The pin idles high; resetting this stage low would fake a pin reset after release.
      pinSync <= 2'h3;
      wdtSync <= 2'h0;
    end
    else if (clkEn)
    begin
      porSync <= {porSync[0], supplyAbovePor};
      bodSync <= {bodSync[0], supplyBelowBrownout};
      pinSync <= {pinSync[0], resetPin_b};
      wdtSync <= {wdtSync[0], watchdogExpire};
    end
  end

  // ==========================================================================
  // Control registers
  // ==========================================================================
  logic [3:0] causeFlags;
  logic [3:0] ctrl;
  logic       sleepActive;
  rsp_sleep_t sleepMode;
  logic       wrFire;
  logic [7:0] wrAddr;
  logic [31:0] wrData;
  logic       haveAw;
  logic       haveW;
  logic       wrStrb;

  // ==========================================================================
  // Brown-out filter
  // ==========================================================================
  // Short dips are ignored; the counter needs the full minimum period low.
  logic [11:0] bodCount;
  logic        brownoutTrip;
  logic        bodActive;

  assign bodActive = brownout_enable_fuse;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bodCount     <= 12'h000;
      brownoutTrip <= 1'b0;
    end
    else if (clkEn)
    begin
      if (bodActive && bodSync[1])
      begin
        if (bodCount < 12'(BROWNOUT_MIN_CYCLES))
        begin
          bodCount <= bodCount + 12'h001;
        end
        else
        begin
          brownoutTrip <= 1'b1;
        end
      end
      else
      begin
        bodCount     <= 12'h000;
        brownoutTrip <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Watchdog pulse
  // ==========================================================================
  logic wdtPrev;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wdtPrev            <= 1'b0;
      watchdogResetPulse <= 1'b0;
    end
    else if (clkEn)
    begin
      wdtPrev            <= wdtSync[1];
      watchdogResetPulse <= wdtSync[1] && !wdtPrev && ctrl[RSP_CTRL_WDOG];
    end
  end

  // ==========================================================================
  // Source merge and delay sequencer
  // ==========================================================================
  logic       porActive;
  logic       pinActive;
  logic       anySource;
  rsp_state_t state;
  logic [TIMEOUT_W-1:0] delayCount;

  assign porActive = !porSync[1];
  assign pinActive = !pinSync[1];
  assign anySource = porActive || pinActive || brownoutTrip || watchdogResetPulse;

  // Port reset is taken from the synchronised sources, so it acts only while the clock runs.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      portReset_b <= 1'b0;
    end
    else if (clkEn)
    begin
      portReset_b <= !anySource;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state       <= RSP_ST_HOLD;
      delayCount  <= '0;
      coreReset_b <= 1'b0;
    end
    else if (clkEn)
    begin
      case (state)
        RSP_ST_HOLD:
        begin
          coreReset_b <= 1'b0;
          if (!anySource)
          begin
            delayCount <= timeoutFor(clock_select_fuses);
            state      <= RSP_ST_WAIT;
          end
        end
        RSP_ST_WAIT:
        begin
          if (anySource)
          begin
            state <= RSP_ST_HOLD;
          end
          else if (delayCount == TIMEOUT_W'(1))
          begin
            coreReset_b <= 1'b1;
            state       <= RSP_ST_RUN;
          end
          else
          begin
            delayCount <= delayCount - TIMEOUT_W'(1);
          end
        end
        RSP_ST_RUN:
        begin
          if (anySource)
          begin
            coreReset_b <= 1'b0;
            state       <= RSP_ST_HOLD;
          end
        end
        default:
        begin
          state <= RSP_ST_HOLD;
        end
      endcase
    end
  end

  // ==========================================================================
  // Cause flags
  // ==========================================================================
  // A new cause wins over a software clear in the same cycle.
  logic [3:0] causeSet;
  logic [3:0] causeKeep;

  assign causeSet  = {watchdogResetPulse, brownoutTrip, pinActive, porActive};
  assign causeKeep = (wrFire && wrAddr == RSP_ADDR_CAUSE && wrStrb) ? wrData[3:0] : 4'hF;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      causeFlags <= RSP_CAUSE_RST;
    end
    else if (clkEn)
    begin
      if (porActive)
      begin
        causeFlags <= 4'h1;
      end
      else
      begin
        causeFlags <= (causeFlags & causeKeep) | causeSet;
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite write channel
  // ==========================================================================
  assign wrFire = haveAw && haveW && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      haveAw        <= 1'b0;
      haveW         <= 1'b0;
      wrAddr        <= 8'h00;
      wrData        <= 32'h0000_0000;
      wrStrb        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end
    else if (clkEn)
    begin
      s_axi_awready <= !haveAw && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !haveW && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        haveAw <= 1'b1;
        wrAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        haveW  <= 1'b1;
        wrData <= s_axi_wdata;
        wrStrb <= s_axi_wstrb[0];
      end
      if (wrFire)
      begin
        haveAw       <= 1'b0;
        haveW        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrAddr <= RSP_ADDR_STATUS && wrAddr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl        <= RSP_CTRL_RST;
      sleepActive <= 1'b0;
      sleepMode   <= RSP_SLP_IDLE;
    end
    else if (clkEn && wrFire && wrStrb)
    begin
      if (wrAddr == RSP_ADDR_CTRL)
      begin
        ctrl <= wrData[3:0];
      end
      else if (wrAddr == RSP_ADDR_SLEEP)
      begin
        sleepActive <= wrData[RSP_SLEEP_EN];
        sleepMode   <= rsp_sleep_t'(wrData[RSP_SLEEP_MODE +: 3]);
      end
    end
  end

  // ==========================================================================
  // AXI4-Lite read channel
  // ==========================================================================
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end
    else if (clkEn)
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          RSP_ADDR_CAUSE:  s_axi_rdata <= {28'h000_0000, causeFlags};
          RSP_ADDR_CTRL:   s_axi_rdata <= {28'h000_0000, ctrl};
          RSP_ADDR_SLEEP:  s_axi_rdata <= {28'h000_0000, sleepMode, sleepActive};
          RSP_ADDR_STATUS: s_axi_rdata <= {24'h00_0000, 1'b0, adcExtendedNext, referenceOn,
                                           comparatorOn, coreReset_b, state};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Sleep power gating
  // ==========================================================================
  logic deepSleep;
  logic clocksStopped;
  logic adcPrev;

  assign deepSleep     = sleepActive && sleepMode != RSP_SLP_IDLE && sleepMode != RSP_SLP_ADCNR;
  assign clocksStopped = deepSleep;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      adcPowerOn             <= 1'b0;
      adcPrev                <= 1'b0;
      adcExtendedNext        <= 1'b1;
      comparatorOn           <= 1'b0;
      referenceOn            <= 1'b0;
      brownoutDetectorOn     <= 1'b0;
      watchdogRun            <= 1'b0;
      inputBufferEn          <= '0;
      brownout_trigger_level <= BROWNOUT_LEVEL_LOW_MV;
    end
    else if (clkEn)
    begin
      adcPowerOn <= ctrl[RSP_CTRL_ADC];
      adcPrev    <= ctrl[RSP_CTRL_ADC];
      if (ctrl[RSP_CTRL_ADC] && !adcPrev)
      begin
        adcExtendedNext <= 1'b1;
      end
      else if (wrFire && wrAddr == RSP_ADDR_STATUS)
      begin
        adcExtendedNext <= 1'b0;
      end
      comparatorOn <= ctrl[RSP_CTRL_ACMP] && !deepSleep;
      // The reference may not drop during sleep when the comparator uses it.
      referenceOn <= bodActive || ctrl[RSP_CTRL_ADC] ||
                     (ctrl[RSP_CTRL_ACMP] && ctrl[RSP_CTRL_ACBG]);
      brownoutDetectorOn <= bodActive;
      watchdogRun        <= ctrl[RSP_CTRL_WDOG];
      inputBufferEn      <= clocksStopped ? wakePinMask : {WAKE_PINS{1'b1}};
      // An unprogrammed fuse reads as one and selects the low trigger level.
      brownout_trigger_level <= brownout_level_fuse ? BROWNOUT_LEVEL_LOW_MV
                                                    : BROWNOUT_LEVEL_HIGH_MV;
    end
  end

endmodule

// ### pkg/rsp_pkg.sv
// Package with constants and types for the reset and sleep power-gating block.
package rsp_pkg;

  // ==========================================================================
  // Register map (byte addresses, chosen for this block)
  // ==========================================================================
  localparam logic [7:0] RSP_ADDR_CAUSE  = 8'h00;
  localparam logic [7:0] RSP_ADDR_CTRL   = 8'h04;
  localparam logic [7:0] RSP_ADDR_SLEEP  = 8'h08;
  localparam logic [7:0] RSP_ADDR_STATUS = 8'h0C;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int RSP_CAUSE_POR = 0;
  localparam int RSP_CAUSE_EXT = 1;
  localparam int RSP_CAUSE_BOR = 2;
  localparam int RSP_CAUSE_WDT = 3;

  localparam int RSP_CTRL_ADC   = 0;
  localparam int RSP_CTRL_ACMP  = 1;
  localparam int RSP_CTRL_ACBG  = 2;
  localparam int RSP_CTRL_WDOG  = 3;

  localparam int RSP_SLEEP_EN   = 0;
  localparam int RSP_SLEEP_MODE = 1;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [3:0] RSP_CAUSE_RST = 4'h0;
  localparam logic [3:0] RSP_CTRL_RST  = 4'h0;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int CLK_MHZ              = 250;
  localparam int BROWNOUT_MIN_NS      = 2000;
  localparam int BROWNOUT_MIN_CYCLES  = (BROWNOUT_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_PIN_MIN_NS     = 1500;
  localparam int RESET_PIN_MIN_CYCLES = (RESET_PIN_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_SEL_W        = 4;

  // Brown-out trigger level in millivolts, chosen by the level fuse.
  localparam logic [12:0] BROWNOUT_LEVEL_LOW_MV  = 13'd2700;
  localparam logic [12:0] BROWNOUT_LEVEL_HIGH_MV = 13'd4000;

  // ==========================================================================
  // Sleep modes (three-bit encoding of the mode select)
  // ==========================================================================
  typedef enum logic [2:0]
  {
    RSP_SLP_IDLE    = 3'h0,
    RSP_SLP_ADCNR   = 3'h1,
    RSP_SLP_PDOWN   = 3'h2,
    RSP_SLP_PSAVE   = 3'h3,
    RSP_SLP_STANDBY = 3'h6,
    RSP_SLP_EXTSTBY = 3'h7
  } rsp_sleep_t;

  // Delay sequencer states.
  typedef enum logic [2:0]
  {
    RSP_ST_HOLD = 3'b001,
    RSP_ST_WAIT = 3'b010,
    RSP_ST_RUN  = 3'b100
  } rsp_state_t;

endpackage

// ### tb/rsp_reset_sleep_properties.sv
// Port-level assertions for the reset sequencer and sleep power gating.
`timescale 1ns/1ps

module rsp_reset_sleep_properties
  import rsp_pkg::*;
#(
  parameter int TIMEOUT_W = 20,
  parameter int WAKE_PINS = 8
)
(
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 rst_b,
  // Sources and fuses
  input wire logic                 supplyAbovePor,
  input wire logic                 resetPin_b,
  input wire logic                 brownout_enable_fuse,
  input wire logic                 brownout_level_fuse,
  input wire logic [WAKE_PINS-1:0] wakePinMask,
  // Outputs under check
  input wire logic                 portReset_b,
  input wire logic                 coreReset_b,
  input wire logic                 watchdogResetPulse,
  input wire logic                 brownoutDetectorOn,
  input wire logic                 watchdogRun,
  input wire logic [WAKE_PINS-1:0] inputBufferEn,
  input wire logic [12:0]          brownout_trigger_level
);
  // ====================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  a_pin_forces_port: assert property (!resetPin_b [*3] |-> ##[0:2] !portReset_b)
    else $error("low reset pin did not reset the ports");
  a_por_forces_port: assert property (!supplyAbovePor [*3] |-> ##[0:2] !portReset_b)
    else $error("supply drop did not reset the ports at once");
  a_core_held_low: assert property (!portReset_b [*2] |-> !coreReset_b)
    else $error("core left reset while a source was active");
  // Eight cycles does not exceed the shortest hold, the default timeout over 8, for any default timeout of 64 or more.
  a_core_stretched: assert property ($rose(coreReset_b) |-> $past(portReset_b, 8))
    else $error("core reset released without the delay count");
  a_wdog_one_cycle: assert property (watchdogResetPulse |=> !watchdogResetPulse)
    else $error("watchdog reset pulse longer than one cycle");
  a_wdog_needs_enable: assert property (watchdogResetPulse |-> watchdogRun)
    else $error("watchdog reset while the watchdog was disabled");
  a_bod_follows_fuse: assert property (brownout_enable_fuse [*4] |-> brownoutDetectorOn)
    else $error("brown-out detector off with its fuse set");
  a_level_unprog: assert property (brownout_level_fuse [*3] |-> brownout_trigger_level == BROWNOUT_LEVEL_LOW_MV)
    else $error("trigger level wrong for unprogrammed fuse");
  a_level_prog: assert property (!brownout_level_fuse [*3] |-> brownout_trigger_level == BROWNOUT_LEVEL_HIGH_MV)
    else $error("trigger level wrong for programmed fuse");
  a_wake_pins_kept: assert property (coreReset_b [*2] |-> (inputBufferEn & wakePinMask) == wakePinMask)
    else $error("wake-up pin input buffer disabled");
endmodule

bind rsp_reset_sleep rsp_reset_sleep_properties #(
  .TIMEOUT_W (TIMEOUT_W),
  .WAKE_PINS (WAKE_PINS)
) i_rsp_reset_sleep_properties (
  .clk, .rst_b, .supplyAbovePor, .resetPin_b, .brownout_enable_fuse, .brownout_level_fuse,
  .wakePinMask, .portReset_b, .coreReset_b, .watchdogResetPulse, .brownoutDetectorOn,
  .watchdogRun, .inputBufferEn, .brownout_trigger_level
);

// ### tb/rsp_reset_sleep_test.sv
// Self-checking bench for the reset sequencer and sleep power gating.
`timescale 1ns/1ps

module rsp_reset_sleep_test;
  import rsp_pkg::*;

  localparam logic [7:0] WAKE_MASK = 8'h05;
  localparam int         TOUT      = 64;

  logic                     clk = 1'b0, rst_b = 1'b0, clkEn = 1'b1;
  logic                     powerUp = 1'b0, dipReq = 1'b0, pinLowReq = 1'b0, expireReq = 1'b0;
  logic                     supplyAbovePor, supplyBelowBrownout, resetPin_b, watchdogExpire;
  logic                     brownout_enable_fuse = 1'b0, brownout_level_fuse = 1'b1;
  logic [TIMEOUT_SEL_W-1:0] clock_select_fuses = 4'h0;
  logic [7:0]               wakePinMask = WAKE_MASK, inputBufferEn;
  logic                     portReset_b, coreReset_b, watchdogResetPulse, adcPowerOn, adcExtendedNext;
  logic                     comparatorOn, referenceOn, brownoutDetectorOn, watchdogRun;
  logic [12:0]              brownout_trigger_level;
  logic [7:0]               s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]              s_axi_wdata = 32'h0000_0000, s_axi_rdata, data;
  logic [3:0]               s_axi_wstrb = 4'hF;
  logic                     s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                     s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]               s_axi_bresp, s_axi_rresp, resp;
  int                       err_total = 0, cmp_count = 0, pulseCount = 0;
  // Row: control, sleep, then expected {adc, comparator, reference, watchdog, deep sleep}.
  logic [15:0]              rows [10] = '{16'h1515, 16'h2108, 16'h2308, 16'h2501, 16'h6705,
                                          16'h600C, 16'h8D03, 16'h0F01, 16'h1114, 16'h9016};

  rsp_reset_sleep #(.TIMEOUT_W(20), .WAKE_PINS(8), .TIMEOUT_DEFAULT(20'h0_0040)) i_rsp_reset_sleep (.*);
  rsp_supply_model i_rsp_supply_model (.clk, .powerUp, .dipReq, .pinLowReq, .expireReq,
    .supplyAbovePor, .supplyBelowBrownout, .resetPin_b, .watchdogExpire);

  always #2 clk = ~clk;
  always @(posedge clk) if (watchdogResetPulse === 1'b1) pulseCount <= pulseCount + 1;

  // ====================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done;
    if (err_total == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Address and data go out together and each drops on its own ready; the response ends it.
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 50);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) begin err_total++; test_done; end
  endtask

  task automatic axr(input logic [7:0] a);
    int n;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 50);
    data = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) begin err_total++; test_done; end
  endtask

  // The window allows for the source synchronisers ahead of the delay counter.
  task automatic relTime(input int lo, input int hi);
    int n;
    n = 0;
    while (coreReset_b !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 300) begin err_total++; test_done; end
    chk(n >= lo && n <= hi, 1'b1);
  endtask

  // ====================
  // Sequence
  initial
  begin
    repeat (8) @(posedge clk);
    chk({portReset_b, coreReset_b, adcExtendedNext}, 3'b001);
    chk(brownout_trigger_level, BROWNOUT_LEVEL_LOW_MV);
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (20) @(posedge clk);
    chk(portReset_b, 1'b0);
    powerUp <= 1'b1;
    relTime(TOUT, TOUT + 10);
    axr(RSP_ADDR_CAUSE);
    chk(data, 32'h0000_0001);
    for (int s = 0; s < 4; s++)
    begin
      clock_select_fuses <= s[3:0];
      pinLowReq <= 1'b1;
      repeat (RESET_PIN_MIN_CYCLES + 25) @(posedge clk);
      chk(portReset_b, 1'b0);
      pinLowReq <= 1'b0;
      relTime(TOUT >> s, (TOUT >> s) + 10);
    end
    axr(RSP_ADDR_CAUSE);
    chk(data, 32'h0000_0003);
    axw(RSP_ADDR_CAUSE, 32'h0000_0000);
    axr(RSP_ADDR_CAUSE);
    chk(data, 32'h0000_0000);
    // A dip shorter than the detection period must leave the ports alone.
    brownout_enable_fuse <= 1'b1;
    dipReq <= 1'b1;
    repeat (BROWNOUT_MIN_CYCLES - 100) @(posedge clk);
    chk(portReset_b, 1'b1);
    dipReq <= 1'b0;
    repeat (10) @(posedge clk);
    dipReq <= 1'b1;
    repeat (BROWNOUT_MIN_CYCLES + 40) @(posedge clk);
    chk(portReset_b, 1'b0);
    dipReq <= 1'b0;
    relTime(TOUT >> 3, (TOUT >> 3) + 10);
    axr(RSP_ADDR_CAUSE);
    chk(data, 32'h0000_0004);
    brownout_enable_fuse <= 1'b0;
    brownout_level_fuse <= 1'b0;
    dipReq <= 1'b1;
    repeat (BROWNOUT_MIN_CYCLES + 40) @(posedge clk);
    chk(portReset_b, 1'b1);
    chk(brownout_trigger_level, BROWNOUT_LEVEL_HIGH_MV);
    dipReq <= 1'b0;
    brownout_level_fuse <= 1'b1;
    foreach (rows[i])
    begin
      axw(RSP_ADDR_CTRL, rows[i][15:12]);
      axw(RSP_ADDR_SLEEP, rows[i][11:8]);
      repeat (4) @(posedge clk);
      chk({adcPowerOn, comparatorOn, referenceOn, watchdogRun}, rows[i][4:1]);
      chk(inputBufferEn, rows[i][0] ? WAKE_MASK : 8'hFF);
    end
    axw(RSP_ADDR_SLEEP, 32'h0000_0000);
    axw(RSP_ADDR_CTRL, 32'h0000_0001);
    axw(RSP_ADDR_STATUS, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk(adcExtendedNext, 1'b0);
    axw(RSP_ADDR_CTRL, 32'h0000_0000);
    axw(RSP_ADDR_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk(adcExtendedNext, 1'b1);
    axw(RSP_ADDR_CTRL, 32'h0000_0000);
    expireReq <= 1'b1;
    repeat (20) @(posedge clk);
    chk(pulseCount, 0);
    chk(coreReset_b, 1'b1);
    expireReq <= 1'b0;
    axw(RSP_ADDR_CTRL, 32'h0000_0008);
    axw(RSP_ADDR_CAUSE, 32'h0000_0000);
    expireReq <= 1'b1;
    repeat (8) @(posedge clk);
    chk(coreReset_b, 1'b0);
    relTime(1, (TOUT >> 3) + 8);
    chk(pulseCount, 1);
    expireReq <= 1'b0;
    axr(RSP_ADDR_CAUSE);
    chk(data, 32'h0000_0008);
    axw(8'h10, 32'h0000_000F);
    chk(resp, 2'h2);
    axr(8'h10);
    chk(resp, 2'h2);
    chk(data, 32'h0000_0000);
    powerUp <= 1'b0;
    repeat (6) @(posedge clk);
    chk(portReset_b, 1'b0);
    powerUp <= 1'b1;
    // With the enable low the delay count stands still, so release comes late by the frozen time.
    repeat (6) @(posedge clk);
    clkEn <= 1'b0;
    repeat (20) @(posedge clk);
    chk(coreReset_b, 1'b0);
    clkEn <= 1'b1;
    relTime((TOUT >> 3) - 2, (TOUT >> 3) + 2);
    axr(RSP_ADDR_CAUSE);
    chk(data, 32'h0000_0001);
    test_done;
  end
endmodule

// ### tb/rsp_supply_model.sv
// Behavioural supply monitor, external reset pin and watchdog that feed the sequencer.
`timescale 1ns/1ps

module rsp_supply_model
(
  // Clock
  input  wire logic clk,
  // Requests from the bench
  input  wire logic powerUp,
  input  wire logic dipReq,
  input  wire logic pinLowReq,
  input  wire logic expireReq,
  // Source levels toward the block
  output logic      supplyAbovePor      = 1'b0,
  output logic      supplyBelowBrownout = 1'b0,
  output logic      resetPin_b          = 1'b1,
  output logic      watchdogExpire      = 1'b0
);
  // ====================
  // Source levels
  // Levels move just after the edge, like analog comparators settling between samples.
  // The pin stays low for as long as the bench asks; the bench keeps it past the minimum width.
  always @(posedge clk)
  begin
    supplyAbovePor      <= powerUp;
    supplyBelowBrownout <= dipReq;
    resetPin_b          <= !pinLowReq;
    watchdogExpire      <= expireReq;
  end
endmodule
